// file: design/frwd_pkg.sv
// Constants for the fault response, watchdog and status register bank
package frwd_pkg;

   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [7:0] ADDR_CHANNEL_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_FAULT_RESPONSE_CONFIG = 8'h01;
   localparam logic [7:0] ADDR_WATCHDOG_TAP_SELECT = 8'h02;
   localparam logic [7:0] ADDR_FAULT_STATUS_ONE = 8'h03;
   localparam logic [7:0] ADDR_FAULT_STATUS_TWO = 8'h04;
   localparam logic [7:0] ADDR_FAULT_STATUS_THREE = 8'h05;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int CH1_ENABLE_BIT = 0;
   localparam int CH2_ENABLE_BIT = 2;
   localparam int WD_ENABLE_BIT = 4;
   localparam int LIMP_HOME_BIT = 5;
   localparam int FT_LIMIT_LSB = 6;
   localparam int CH2_THERMAL_SEL_BIT = 5;
   localparam int CH2_HS_SEL_BIT = 4;
   localparam int CH2_LS_SEL_BIT = 3;
   localparam int CH1_THERMAL_SEL_BIT = 2;
   localparam int CH1_HS_SEL_BIT = 1;
   localparam int CH1_LS_SEL_BIT = 0;
   localparam int ST1_CH2_LSB = 4;
   localparam int ST2_CH1_THERMAL_BIT = 2;
   localparam int ST2_CH2_THERMAL_BIT = 5;
   localparam int ST3_EXPIRY_LSB = 4;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] CHANNEL_CONFIG_RESET = 8'h10;
   localparam logic [7:0] FAULT_RESPONSE_RESET = 8'h00;
   localparam logic [3:0] TAP_SELECT_RESET = 4'h8;
   localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;

   // ***************************************************
   // Watchdog shape
   // ***************************************************
   localparam int WD_COUNTER_W = 25;
   localparam int WD_TAP_BASE = 16;
   localparam int WD_TAP_MAX = 24;
   localparam logic [1:0] WD_EXPIRY_LIMIT = 2'h3;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int FT_BASE_TIME_US = 3600;
   localparam int FT_BASE_CYCLES = (FT_BASE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int FT_COUNT_W = 22;
   // Shortest watchdog period, 6.1 ms at counter bit 16
   localparam int WD_MIN_PERIOD_US = 6100;
   localparam int WD_TICK_CYCLES = (WD_MIN_PERIOD_US * 1000) / (CLK_PERIOD_NS * (1 << WD_TAP_BASE));
   localparam int WD_PRE_W = 4;

endpackage

// file: design/frwd_fault_timer.sv
// Per-channel current-limit fault timer for auto-restart
`timescale 1ns/1ps
`default_nettype none

module frwd_fault_timer #(
   parameter int BASE_CYCLES = frwd_pkg::FT_BASE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic [1:0] limit_code,
   // Status
   output logic busy
);

   typedef struct packed {
      logic busy;
      logic [frwd_pkg::FT_COUNT_W-1:0] cnt;
   } frwd_ft_state_t;

   frwd_ft_state_t s_r;
   frwd_ft_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (start) begin
         // Each code step doubles the limit
         s_nxt.busy = 1'b1;
         s_nxt.cnt = (frwd_pkg::FT_COUNT_W'(BASE_CYCLES) << limit_code) - 1'b1;
      end else if (s_r.busy) begin
         if (s_r.cnt == '0) begin
            s_nxt.busy = 1'b0;
         end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;

endmodule

`default_nettype wire

// file: design/frwd_regs.sv
// Fault response, watchdog tap and read-clear status register bank
`timescale 1ns/1ps
`default_nettype none

module frwd_regs #(
   parameter int FT_BASE_CYCLES = frwd_pkg::FT_BASE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register access from the serial frame logic
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic rd_resp_done,
   input wire logic txn_valid,
   output logic [7:0] reg_rdata,
   // Fault detectors, asynchronous levels, bit 0 is channel 1
   input wire logic [1:0] det_comp_ov,
   input wire logic [1:0] det_short,
   input wire logic [1:0] det_hs_limit,
   input wire logic [1:0] det_ls_limit,
   input wire logic [1:0] det_thermal,
   // Channel and mode control
   output logic [1:0] channel_run,
   output logic limp_home
);

   // ***************************************************
   // Types and helpers
   // ***************************************************
   typedef struct packed {
      logic [1:0] ch_en;
      logic wd_en;
      logic limp;
      logic [7:0] frc;
      logic [3:0] tap;
      logic [7:0] st1;
      logic [1:0] st2_th;
      logic [1:0] wd_expiries;
      logic [frwd_pkg::WD_COUNTER_W-1:0] wd_ctr;
      logic [frwd_pkg::WD_PRE_W-1:0] wd_pre;
      logic rd_pend;
      logic [7:0] rd_addr;
      logic [7:0] rdata;
      logic [9:0] sync1;
      logic [9:0] sync2;
      logic [9:0] prev;
      logic [1:0] run;
   } frwd_state_t;

   // Counter bit that ends a watchdog period
   function automatic logic [4:0] frwd_tap_bit(input logic [3:0] code);
      if (code[3]) begin
         return 5'(frwd_pkg::WD_TAP_MAX);
      end
      return 5'(frwd_pkg::WD_TAP_BASE) + {2'b00, code[2:0]};
   endfunction

   // Pending read completes on this status register
   function automatic logic frwd_clear_hit(input logic done, input logic pend,
                                          input logic [7:0] pend_addr, input logic [7:0] addr);
      return done && pend && (pend_addr == addr);
   endfunction

   // Write strobe aimed at one register
   function automatic logic frwd_wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
      return wr && (addr == target);
   endfunction

   // ***************************************************
   // Reset release
   // ***************************************************
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // ***************************************************
   // State
   // ***************************************************
   frwd_state_t s_r;
   frwd_state_t s_nxt;

   // Synchronised detector levels, grouped per kind
   logic [1:0] cov;
   logic [1:0] shrt;
   logic [1:0] hs;
   logic [1:0] ls;
   logic [1:0] th;
   logic [1:0] hs_rise;
   logic [1:0] ls_rise;
   logic [1:0] th_rise;

   assign cov = s_r.sync2[1:0];
   assign shrt = s_r.sync2[3:2];
   assign hs = s_r.sync2[5:4];
   assign ls = s_r.sync2[7:6];
   assign th = s_r.sync2[9:8];
   assign hs_rise = hs & ~s_r.prev[5:4];
   assign ls_rise = ls & ~s_r.prev[7:6];
   assign th_rise = th & ~s_r.prev[9:8];

   // Per-channel latch selections and shared fault timer limit
   logic [1:0] th_latch_sel;
   logic [1:0] hs_latch_sel;
   logic [1:0] ls_latch_sel;
   logic [1:0] fault_timer_limit;

   assign th_latch_sel = {s_r.frc[frwd_pkg::CH2_THERMAL_SEL_BIT], s_r.frc[frwd_pkg::CH1_THERMAL_SEL_BIT]};
   assign hs_latch_sel = {s_r.frc[frwd_pkg::CH2_HS_SEL_BIT], s_r.frc[frwd_pkg::CH1_HS_SEL_BIT]};
   assign ls_latch_sel = {s_r.frc[frwd_pkg::CH2_LS_SEL_BIT], s_r.frc[frwd_pkg::CH1_LS_SEL_BIT]};
   assign fault_timer_limit = s_r.frc[frwd_pkg::FT_LIMIT_LSB +: 2];

   // ***************************************************
   // Fault timers
   // ***************************************************
   logic [1:0] timer_start;
   logic [1:0] timer_busy;
   logic [1:0] latch_event;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_ch
         // Auto-restart current limits arm the timer; latch selections kill the channel
         assign timer_start[g] = (hs_rise[g] & ~hs_latch_sel[g]) | (ls_rise[g] & ~ls_latch_sel[g]);
         assign latch_event[g] = (hs_rise[g] & hs_latch_sel[g]) | (ls_rise[g] & ls_latch_sel[g])
                                 | (th_rise[g] & th_latch_sel[g]);

         frwd_fault_timer #(
            .BASE_CYCLES(FT_BASE_CYCLES)
         ) u_timer (
            .clk(clk),
            .rst_n(rst_n),
            .start(timer_start[g]),
            .limit_code(fault_timer_limit),
            .busy(timer_busy[g])
         );
      end
   endgenerate

   // ***************************************************
   // Status conditions
   // ***************************************************
   logic [7:0] st1_cond;
   logic [1:0] ch_fault;

   // Bits 3..0 per channel: ls, hs, short, comp-ov
   assign st1_cond = {ls[1], hs[1], shrt[1], cov[1], ls[0], hs[0], shrt[0], cov[0]};
   assign ch_fault = {|s_r.st1[frwd_pkg::ST1_CH2_LSB +: 4] | s_r.st2_th[1],
                      |s_r.st1[0 +: 4] | s_r.st2_th[0]};

   // ***************************************************
   // Read data
   // ***************************************************
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         frwd_pkg::ADDR_CHANNEL_CONFIG: begin
            rd_mux[frwd_pkg::CH1_ENABLE_BIT] = s_r.ch_en[0];
            rd_mux[frwd_pkg::CH2_ENABLE_BIT] = s_r.ch_en[1];
            rd_mux[frwd_pkg::WD_ENABLE_BIT] = s_r.wd_en;
            rd_mux[frwd_pkg::LIMP_HOME_BIT] = s_r.limp;
         end
         frwd_pkg::ADDR_FAULT_RESPONSE_CONFIG: begin
            rd_mux = s_r.frc;
         end
         frwd_pkg::ADDR_WATCHDOG_TAP_SELECT: begin
            rd_mux = {4'h0, s_r.tap};
         end
         frwd_pkg::ADDR_FAULT_STATUS_ONE: begin
            rd_mux = s_r.st1;
         end
         frwd_pkg::ADDR_FAULT_STATUS_TWO: begin
            rd_mux[frwd_pkg::ST2_CH1_THERMAL_BIT] = s_r.st2_th[0];
            rd_mux[frwd_pkg::ST2_CH2_THERMAL_BIT] = s_r.st2_th[1];
         end
         frwd_pkg::ADDR_FAULT_STATUS_THREE: begin
            rd_mux[frwd_pkg::ST3_EXPIRY_LSB +: 2] = s_r.wd_expiries;
            rd_mux[1:0] = ch_fault;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // ***************************************************
   // Next state
   // ***************************************************
   logic clr1;
   logic clr2;
   logic clr3;
   logic wd_tick;
   logic wd_expire;
   logic [1:0] expiry_base;
   logic wr_cfg;

   always_comb begin
      s_nxt = s_r;

      // Detector synchronisers; first stage feeds only the second
      s_nxt.sync1 = {det_thermal, det_ls_limit, det_hs_limit, det_short, det_comp_ov};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev = s_r.sync2;

      // Clears land on the response transfer, not the command
      clr1 = frwd_clear_hit(rd_resp_done, s_r.rd_pend, s_r.rd_addr, frwd_pkg::ADDR_FAULT_STATUS_ONE);
      clr2 = frwd_clear_hit(rd_resp_done, s_r.rd_pend, s_r.rd_addr, frwd_pkg::ADDR_FAULT_STATUS_TWO);
      clr3 = frwd_clear_hit(rd_resp_done, s_r.rd_pend, s_r.rd_addr, frwd_pkg::ADDR_FAULT_STATUS_THREE);

      // Live condition re-sets the bit, so a persisting cause survives the read
      s_nxt.st1 = st1_cond | (s_r.st1 & ~{8{clr1}});
      s_nxt.st2_th = th | (s_r.st2_th & ~{2{clr2}});

      // Read command captures data; response end retires the pending read
      if (rd_resp_done) begin
         s_nxt.rd_pend = 1'b0;
      end
      if (reg_rd) begin
         s_nxt.rd_pend = 1'b1;
         s_nxt.rd_addr = reg_addr;
         s_nxt.rdata = rd_mux;
      end

      // Register writes
      wr_cfg = frwd_wr_hit(reg_wr, reg_addr, frwd_pkg::ADDR_CHANNEL_CONFIG);
      if (wr_cfg) begin
         s_nxt.ch_en[0] = reg_wdata[frwd_pkg::CH1_ENABLE_BIT];
         s_nxt.ch_en[1] = reg_wdata[frwd_pkg::CH2_ENABLE_BIT];
         s_nxt.wd_en = reg_wdata[frwd_pkg::WD_ENABLE_BIT];
         s_nxt.limp = reg_wdata[frwd_pkg::LIMP_HOME_BIT];
      end
      if (frwd_wr_hit(reg_wr, reg_addr, frwd_pkg::ADDR_FAULT_RESPONSE_CONFIG)) begin
         s_nxt.frc = reg_wdata;
      end
      if (frwd_wr_hit(reg_wr, reg_addr, frwd_pkg::ADDR_WATCHDOG_TAP_SELECT)) begin
         s_nxt.tap = reg_wdata[3:0];
      end

      // Latch-off beats a same-cycle host re-enable
      s_nxt.ch_en = s_nxt.ch_en & ~latch_event;

      // Watchdog prescaler and counter
      wd_tick = (s_r.wd_pre == frwd_pkg::WD_PRE_W'(frwd_pkg::WD_TICK_CYCLES - 1));
      wd_expire = 1'b0;
      if (!s_r.wd_en || txn_valid) begin
         s_nxt.wd_pre = '0;
         s_nxt.wd_ctr = '0;
      end else if (wd_tick) begin
         s_nxt.wd_pre = '0;
         if (s_r.wd_ctr[frwd_tap_bit(s_r.tap)]) begin
            wd_expire = 1'b1;
            s_nxt.wd_ctr = '0;
         end else begin
            s_nxt.wd_ctr = s_r.wd_ctr + 1'b1;
         end
      end else begin
         s_nxt.wd_pre = s_r.wd_pre + 1'b1;
      end

      // Expiry count; a same-cycle expiry outlives the read clear
      expiry_base = clr3 ? 2'b00 : s_r.wd_expiries;
      s_nxt.wd_expiries = expiry_base;
      if (wd_expire && (expiry_base != frwd_pkg::WD_EXPIRY_LIMIT)) begin
         s_nxt.wd_expiries = expiry_base + 1'b1;
         if (expiry_base + 1'b1 == frwd_pkg::WD_EXPIRY_LIMIT) begin
            s_nxt.limp = 1'b1;
         end
      end

      // Channel run: enabled, not in restart hold, not over temperature
      s_nxt.run = s_nxt.ch_en & ~timer_busy & ~th;
   end

   // ***************************************************
   // Registers
   // ***************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.ch_en <= 2'b00;
         s_r.wd_en <= frwd_pkg::CHANNEL_CONFIG_RESET[frwd_pkg::WD_ENABLE_BIT];
         s_r.limp <= frwd_pkg::CHANNEL_CONFIG_RESET[frwd_pkg::LIMP_HOME_BIT];
         s_r.frc <= frwd_pkg::FAULT_RESPONSE_RESET;
         s_r.tap <= frwd_pkg::TAP_SELECT_RESET;
         s_r.st1 <= frwd_pkg::FAULT_STATUS_RESET;
         s_r.st2_th <= 2'b00;
         s_r.wd_expiries <= 2'b00;
         s_r.wd_ctr <= '0;
         s_r.wd_pre <= '0;
         s_r.rd_pend <= 1'b0;
         s_r.rd_addr <= 8'h00;
         s_r.rdata <= 8'h00;
         s_r.sync1 <= '0;
         s_r.sync2 <= '0;
         s_r.prev <= '0;
         s_r.run <= 2'b00;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign reg_rdata = s_r.rdata;
   assign channel_run = s_r.run;
   assign limp_home = s_r.limp;

endmodule

`default_nettype wire

// file: tb/frwd_regs_assertions.sv
// Checker for the fault response, watchdog tap and status register bank
`timescale 1ns/1ps
`default_nettype none
module frwd_regs_checker #(
   parameter int FT_BASE_CYCLES = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register access
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Detectors and channel control
   input wire logic [1:0] det_short,
   input wire logic [1:0] det_hs_limit,
   input wire logic [1:0] det_thermal,
   input wire logic [1:0] channel_run,
   input wire logic limp_home
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   tap_reserved_a: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[7:4] == 4'h0)
      else $error("tap reserved bits not zero");
   tap_writeback_a: assert property (reg_wr && reg_addr == 8'h02 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h02
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h0f)) else $error("tap code not read back");
   status_two_rsvd_a: assert property (reg_rd && reg_addr == 8'h04 |=> (reg_rdata & 8'hdb) == 8'h00)
      else $error("status two unused bits set");
   short_sticky_a: assert property (det_short[0] [*5] ##0 (reg_rd && reg_addr == 8'h03) |=> reg_rdata[1])
      else $error("short flag missing in status one");
   hs_stops_run_a: assert property ($rose(det_hs_limit[0]) |-> ##6 !channel_run[0])
      else $error("channel kept running after high side limit");
   thermal_off_a: assert property (det_thermal[1] [*6] |-> !channel_run[1])
      else $error("channel running while hot");
   limp_write_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[5] |=> limp_home)
      else $error("limp home not entered by write");
endmodule
bind frwd_regs frwd_regs_checker #(.FT_BASE_CYCLES(FT_BASE_CYCLES)) u_frwd_regs_checker (.clk(clk),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .det_short(det_short), .det_hs_limit(det_hs_limit), .det_thermal(det_thermal),
   .channel_run(channel_run), .limp_home(limp_home));
`default_nettype wire

// file: tb/frwd_host_model.sv
// Host model issuing register transfers to the bank
`timescale 1ns/1ps
`default_nettype none
module frwd_host_model (
   // Clock
   input wire logic clk,
   // Register transfers
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic rd_resp_done,
   output logic txn_valid,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd_resp_done = 1'b0;
      txn_valid = 1'b0;
   end
   // Idle lines flip so a stale value is never mistaken for a live one
   task automatic idle_bus();
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      txn_valid <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      txn_valid <= 1'b0;
      idle_bus();
   endtask
   task automatic rd(input logic [7:0] a, input logic resp, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      txn_valid <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      txn_valid <= 1'b0;
      idle_bus();
      @(posedge clk);
      d = reg_rdata;
      if (resp) begin
         rd_resp_done <= 1'b1;
         @(posedge clk);
         rd_resp_done <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the fault response and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int FT = 20;
   localparam logic [7:0] CFG = frwd_pkg::ADDR_CHANNEL_CONFIG;
   localparam logic [7:0] FRS = frwd_pkg::ADDR_FAULT_RESPONSE_CONFIG;
   localparam logic [7:0] TAP = frwd_pkg::ADDR_WATCHDOG_TAP_SELECT;
   localparam logic [7:0] ST1 = frwd_pkg::ADDR_FAULT_STATUS_ONE;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} frwd_row_t;
   frwd_row_t rows [7] = '{'{CFG, 8'hff, 8'h35}, '{FRS, 8'hff, 8'hff}, '{TAP, 8'hff, 8'h0f},
      '{ST1, 8'hff, 8'h00}, '{8'h04, 8'hff, 8'h00}, '{8'h07, 8'hff, 8'h00}, '{CFG, 8'h00, 8'h00}};
   frwd_row_t rst_rows [4] = '{'{CFG, 8'h00, 8'h10}, '{FRS, 8'h00, 8'h00}, '{TAP, 8'h00, 8'h08},
      '{ST1, 8'h00, 8'h00}};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, rd_resp_done, txn_valid, limp_home;
   logic [1:0] det_comp_ov = 2'h0, det_short = 2'h0, det_hs_limit = 2'h0, det_ls_limit = 2'h0;
   logic [1:0] det_thermal = 2'h0, channel_run;
   int miscompares = 0;
   int tests_run = 0;
   int n;

   always #5 clk = ~clk;

   frwd_regs #(.FT_BASE_CYCLES(FT)) u_frwd_regs (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_resp_done(rd_resp_done),
      .txn_valid(txn_valid), .reg_rdata(reg_rdata), .det_comp_ov(det_comp_ov), .det_short(det_short),
      .det_hs_limit(det_hs_limit), .det_ls_limit(det_ls_limit), .det_thermal(det_thermal),
      .channel_run(channel_run), .limp_home(limp_home));
   frwd_host_model u_frwd_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_resp_done(rd_resp_done), .txn_valid(txn_valid),
      .reg_rdata(reg_rdata));

   // ********************
   // Helpers
   // ********************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic set_det(input int kind, input int ch, input logic v);
      case (kind)
         0: det_comp_ov[ch] <= v;
         1: det_short[ch] <= v;
         2: det_hs_limit[ch] <= v;
         default: det_ls_limit[ch] <= v;
      endcase
   endtask

   // ********************
   // Tests
   // ********************
   initial begin
      do_reset();
      foreach (rows[i]) begin
         u_frwd_host_model.wr(rows[i].addr, rows[i].wdata);
         u_frwd_host_model.rd(rows[i].addr, 1'b0, d);
         check(d, rows[i].exp);
      end
      for (int c = 0; c < 16; c++) begin
         u_frwd_host_model.wr(TAP, 8'(c) | 8'hf0);
         u_frwd_host_model.rd(TAP, 1'b0, d);
         check(d, 8'(c));
      end
      do_reset();
      foreach (rst_rows[i]) begin
         u_frwd_host_model.rd(rst_rows[i].addr, 1'b0, d);
         check(d, rst_rows[i].exp);
      end
      for (int k = 0; k < 8; k++) begin
         set_det(k % 4, k / 4, 1'b1);
         repeat (6) @(posedge clk);
         u_frwd_host_model.rd(ST1, 1'b1, d);
         check(d, 8'h01 << k);
         set_det(k % 4, k / 4, 1'b0);
         repeat (4) @(posedge clk);
         u_frwd_host_model.rd(ST1, 1'b0, d);
         check(d, 8'h01 << k);
         u_frwd_host_model.rd(ST1, 1'b1, d);
         check(d, 8'h01 << k);
         u_frwd_host_model.rd(ST1, 1'b0, d);
         check(d, 8'h00);
      end
      repeat (50) @(posedge clk);
      u_frwd_host_model.wr(CFG, 8'h15);
      u_frwd_host_model.wr(FRS, 8'h02);
      repeat (3) @(negedge clk);
      check(8'(channel_run), 8'h03);
      @(posedge clk);
      set_det(2, 0, 1'b1);
      @(posedge clk);
      set_det(2, 0, 1'b0);
      repeat (200) @(negedge clk);
      check(8'(channel_run), 8'h02);
      u_frwd_host_model.rd(CFG, 1'b0, d);
      check(d, 8'h14);
      u_frwd_host_model.wr(CFG, 8'h15);
      repeat (3) @(negedge clk);
      check(8'(channel_run), 8'h03);
      // Auto restart for every timer code: even passes high side ch1, odd passes low side ch2
      for (int k = 0; k < 8; k++) begin
         u_frwd_host_model.wr(FRS, 8'((k / 2) << 6));
         set_det(2 + k % 2, k % 2, 1'b1);
         @(posedge clk);
         set_det(2 + k % 2, k % 2, 1'b0);
         n = 0;
         while (channel_run[k % 2] !== 1'b0 && n < 10) begin
            @(negedge clk);
            n++;
         end
         n = 0;
         while (channel_run[k % 2] === 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
         end
         check(8'(n >= (FT << (k / 2)) - 2 && n <= (FT << (k / 2)) + 2), 8'h01);
      end
      @(posedge clk);
      det_thermal[1] <= 1'b1;
      repeat (30) @(negedge clk);
      check(8'(channel_run), 8'h01);
      u_frwd_host_model.rd(8'h04, 1'b1, d);
      check(d, 8'h20);
      det_thermal[1] <= 1'b0;
      repeat (6) @(negedge clk);
      check(8'(channel_run), 8'h03);
      u_frwd_host_model.wr(CFG, 8'h35);
      @(negedge clk);
      check(8'(limp_home), 8'h01);
      u_frwd_host_model.wr(CFG, 8'h15);
      @(negedge clk);
      check(8'(limp_home), 8'h00);
      u_frwd_host_model.rd(8'h05, 1'b0, d);
      check(d, 8'h03);
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
endmodule
`default_nettype wire
